// ===== sim/sts_host_model.sv
// Bus host model that issues register accesses to the bank
`default_nettype none
module sts_host_model #(
    parameter int LIMIT = 64
) (
    input  wire logic        aclk,    // Clock
    output var  logic [7:0]  awaddr,  // Write address
    output var  logic        awvalid, // Write address valid
    input  wire logic        awready, // Write address ready
    output var  logic [31:0] wdata,   // Write data
    output var  logic [3:0]  wstrb,   // Write strobes
    output var  logic        wvalid,  // Write data valid
    input  wire logic        wready,  // Write data ready
    input  wire logic [1:0]  bresp,   // Write response
    input  wire logic        bvalid,  // Response valid
    output var  logic        bready,  // Response ready
    output var  logic [7:0]  araddr,  // Read address
    output var  logic        arvalid, // Read address valid
    input  wire logic        arready, // Read address ready
    input  wire logic [31:0] rdata,   // Read data
    input  wire logic [1:0]  rresp,   // Read response
    input  wire logic        rvalid,  // Read data valid
    output var  logic        rready   // Read data ready
);
    timeunit 1ns;
    timeprecision 1ns;

    // Idle bus from time zero
    initial begin
        {awvalid, wvalid, bready, arvalid, rready} <= 5'h00;
        {awaddr, araddr, wstrb} <= 20'h00000;
        wdata <= 32'h0000_0000;
    end

    // Ready is looked at mid-cycle, so the edge that follows is the handshake edge
    task automatic write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                         output logic [1:0] resp, output logic ok);
        int   n;
        logic ta, tw, tb;
        // Let an edge pass so bready is never lowered and raised in one step
        @(posedge aclk);
        awaddr  <= a;
        wdata   <= d;
        wstrb   <= s;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        ok = 1'b0;
        resp = 2'h0;
        n = 0;
        while (!ok && n < LIMIT) begin
            @(negedge aclk);
            ta = awvalid && awready;
            tw = wvalid && wready;
            tb = bvalid && bready;
            if (tb) resp = bresp;
            @(posedge aclk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            if (tb) bready <= 1'b0;
            ok = tb;
            n++;
        end
    endtask

    // Read keeps rready up until the data arrives
    task automatic read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp,
                        output logic ok);
        int   n;
        logic ta, tr;
        // Let an edge pass so rready is never lowered and raised in one step
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        ok = 1'b0;
        n = 0;
        while (!ok && n < LIMIT) begin
            @(negedge aclk);
            ta = arvalid && arready;
            tr = rvalid && rready;
            d = rdata;
            resp = rresp;
            @(posedge aclk);
            if (ta) arvalid <= 1'b0;
            if (tr) rready <= 1'b0;
            ok = tr;
            n++;
        end
    endtask
endmodule
`default_nettype wire

// ===== sim/test_switch_threshold_regs_soft_reset.sv
// Self-checking bench for the threshold and soft reset bank
`default_nettype none
`include "sts_regs.svh"
`define CHECK(got, exp) \
    begin \
        tests_run++; \
        if ((got) !== (exp)) begin \
            n_mismatch++; \
            $display("Error at %0t: got %0h, expected %0h", $time, (got), (exp)); \
        end \
    end
module test_switch_threshold_regs_soft_reset;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [7:0] SOFT_A = {`STS_IDX_SOFT_RESET, 2'b00};
    logic              aclk = 1'b0;
    logic              aresetn;
    logic [7:0]        awaddr, araddr;
    logic [31:0]       wdata, rdata;
    logic [3:0]        wstrb;
    logic [1:0]        bresp, rresp;
    logic              awvalid, awready, wvalid, wready, bvalid, bready;
    logic              arvalid, arready, rvalid, rready, soft_pulse;
    sts_pkg::sts_thr_t thr [12];
    int                n_mismatch = 0;
    int                tests_run = 0;
    int                n_pulse = 0;

    sts_top u_sts_top (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .x_operate_threshold_one(thr[0]), .x_return_threshold_one(thr[1]),
        .x_operate_threshold_two(thr[2]), .x_return_threshold_two(thr[3]),
        .y_operate_threshold_one(thr[4]), .y_return_threshold_one(thr[5]),
        .y_operate_threshold_two(thr[6]), .y_return_threshold_two(thr[7]),
        .z_operate_threshold_one(thr[8]), .z_return_threshold_one(thr[9]),
        .z_operate_threshold_two(thr[10]), .z_return_threshold_two(thr[11]),
        .soft_reset_request(soft_pulse)
    );

    sts_host_model u_sts_host_model (
        .aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
        .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
        .rresp(rresp), .rvalid(rvalid), .rready(rready)
    );

    // 10 MHz clock
    always #50 aclk = ~aclk;

    // Count request cycles mid-cycle, clear of the edge updates
    always @(negedge aclk) begin
        if (soft_pulse === 1'b1) n_pulse++;
    end

    task automatic print_verdict();
        $display("mismatches %0d, comparisons %0d", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    // Distinct values per register, both signs and the top of range
    function automatic sts_pkg::sts_thr_t val(input int i);
        return (i == 11) ? 16'sh7FFF : 16'sh8000 + 16'(i) * 16'sh0111;
    endfunction

    function automatic logic [7:0] adr(input int i);
        return {`STS_IDX_THR_BASE + 6'(i), 2'b00};
    endfunction

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
        logic [1:0] r;
        logic       ok;
        u_sts_host_model.write(a, d, s, r, ok);
        if (!ok) begin
            n_mismatch++;
            $display("Error at %0t: write timed out", $time);
            print_verdict();
        end else `CHECK(r, er)
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        logic [31:0] d;
        logic [1:0]  r;
        logic        ok;
        u_sts_host_model.read(a, d, r, ok);
        if (!ok) begin
            n_mismatch++;
            $display("Error at %0t: read timed out", $time);
            print_verdict();
        end else begin
            `CHECK(r, er)
            `CHECK(d, ed)
        end
    endtask

    initial begin
        aresetn = 1'b0;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        // Defaults after reset
        for (int i = 0; i < 12; i++) begin
            rd(adr(i), 32'h0000_0000, `STS_RESP_OKAY);
            `CHECK(thr[i], 16'sh0000)
        end
        rd(SOFT_A, 32'h0000_0000, `STS_RESP_OKAY);
        // Full words; the upper half of the bus word is not stored
        for (int i = 0; i < 12; i++) wr(adr(i), {16'hA5A5, val(i)}, 4'hF, `STS_RESP_OKAY);
        for (int i = 0; i < 12; i++) begin
            rd(adr(i), {16'h0000, val(i)}, `STS_RESP_OKAY);
            `CHECK(thr[i], val(i))
        end
        `CHECK(thr[0] < 16'sh0000, 1'b1)
        `CHECK(thr[11] > 16'sh0000, 1'b1)
        // One byte lane at a time, on the word that the lane checks watch
        wr(adr(0), 32'h0000_1234, 4'h1, `STS_RESP_OKAY);
        rd(adr(0), 32'h0000_8034, `STS_RESP_OKAY);
        wr(adr(0), 32'h0000_5600, 4'h2, `STS_RESP_OKAY);
        rd(adr(0), 32'h0000_5634, `STS_RESP_OKAY);
        // Unmapped places answer with an error
        wr(8'h84, 32'h0000_FFFF, 4'hF, `STS_RESP_SLVERR);
        rd(8'hFC, 32'h0000_0000, `STS_RESP_SLVERR);
        // Upper bits set, request bit clear: nothing happens
        wr(SOFT_A, 32'h0000_00FE, 4'h1, `STS_RESP_OKAY);
        rd(SOFT_A, 32'h0000_0000, `STS_RESP_OKAY);
        `CHECK(n_pulse, 0)
        `CHECK(thr[5], val(5))
        // Soft reset request
        wr(SOFT_A, 32'h0000_0001, 4'h1, `STS_RESP_OKAY);
        @(negedge aclk);
        `CHECK(n_pulse, 1)
        `CHECK(soft_pulse, 1'b0)
        for (int i = 0; i < 12; i++) `CHECK(thr[i], 16'sh0000)
        @(posedge aclk);
        rd(SOFT_A, 32'h0000_0000, `STS_RESP_OKAY);
        rd(adr(7), 32'h0000_0000, `STS_RESP_OKAY);
        print_verdict();
    end
endmodule
`default_nettype wire

// ===== verilog/sts_pkg.sv
// Types shared by the threshold bank modules
`default_nettype none
package sts_pkg;
    // Write channel states, Gray along collect -> respond
    typedef enum logic [0:0] {
        STS_WR_COLLECT = 1'b0,
        STS_WR_RESP    = 1'b1
    } sts_wr_state_t;

    typedef logic signed [15:0] sts_thr_t;
endpackage
`default_nettype wire

// ===== verilog/sts_regs.svh
// Offsets, field positions, reset values and timing counts of the threshold bank
// How it works
// R1: Thresholds are signed two's complement values.
// R2: Threshold format matches measurement output words.
// R3: Any in-range value accepted; host stays in range.
// R4: Low byte bits 7:0, high byte 15:8.
// R5: Two operate/return sets per axis, twelve.
// R6: Soft reset request restores every register default.
// R7: Soft reset bit clears itself afterwards.
// R8: Soft reset bit D0 at index 30h.
// R9: Upper soft reset bits ignore writes, read zero.
`ifndef STS_REGS_SVH
`define STS_REGS_SVH

// Register indices; byte address is four times the index
`define STS_IDX_THR_BASE   6'h22
`define STS_IDX_SOFT_RESET 6'h30
`define STS_THR_COUNT      12

// Field positions
`define STS_THR_LO_MSB     7
`define STS_THR_HI_LSB     8
`define STS_SOFT_RESET_BIT 0

// Reset values
`define STS_THR_RESET      16'h0000
`define STS_SOFT_RESET_DEF 1'b0

// Cycles from request taken to answer
`define STS_RD_LATENCY     1
`define STS_WR_LATENCY     1

// AXI responses
`define STS_RESP_OKAY      2'h0
`define STS_RESP_SLVERR    2'h2

`endif

// ===== verilog/sts_soft_reset.sv
// Self-clearing soft reset request bit
`default_nettype none
`include "sts_regs.svh"
module sts_soft_reset (
    input  wire logic aclk,    // System clock
    input  wire logic aresetn, // Synchronous reset, active low
    input  wire logic set,     // Host wrote one to the request bit
    output logic      req      // Request, high for one cycle
);
    // Request lives one cycle, then drops by itself; a new set wins
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            req <= `STS_SOFT_RESET_DEF;
        end else if (set) begin
            req <= 1'b1; // R8
        end else begin
            req <= 1'b0; // R7
        end
    end
endmodule
`default_nettype wire

// ===== verilog/sts_thresh_word.sv
// One 16-bit threshold word with byte lanes and soft reset
`default_nettype none
`include "sts_regs.svh"
module sts_thresh_word #(
    parameter logic [15:0] RESET_VAL = `STS_THR_RESET
) (
    input  wire logic        aclk,      // System clock
    input  wire logic        aresetn,   // Synchronous reset, active low
    input  wire logic        clear,     // Soft reset, back to default
    input  wire logic        wr_en,     // Write this word
    input  wire logic [1:0]  wstrb,     // Byte lane enables
    input  wire logic [15:0] wdata,     // Write data
    output var  sts_pkg::sts_thr_t value // Stored signed threshold
);
    // Soft reset beats a coinciding write so defaults are certain afterwards
    always_ff @(posedge aclk) begin
        if (!aresetn || clear) begin
            value <= RESET_VAL; // R6
        end else if (wr_en) begin
            if (wstrb[0]) begin
                value[`STS_THR_LO_MSB:0] <= wdata[`STS_THR_LO_MSB:0]; // R4
            end
            if (wstrb[1]) begin
                value[15:`STS_THR_HI_LSB] <= wdata[15:`STS_THR_HI_LSB]; // R4
            end
        end
    end
endmodule
`default_nettype wire

// ===== verilog/sts_top.sv
// Threshold and soft reset register bank behind an AXI4-Lite slave
`default_nettype none
`include "sts_regs.svh"
module sts_top #(
    parameter int ADDR_W = 8
) (
    input  wire logic              aclk,                    // System clock
    input  wire logic              aresetn,                 // Synchronous reset, active low
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,            // Write address
    input  wire logic              s_axi_awvalid,           // Write address valid
    output logic                   s_axi_awready,           // Write address ready
    input  wire logic [31:0]       s_axi_wdata,             // Write data
    input  wire logic [3:0]        s_axi_wstrb,             // Write strobes
    input  wire logic              s_axi_wvalid,            // Write data valid
    output logic                   s_axi_wready,            // Write data ready
    output logic [1:0]             s_axi_bresp,             // Write response
    output logic                   s_axi_bvalid,            // Write response valid
    input  wire logic              s_axi_bready,            // Write response ready
    input  wire logic [ADDR_W-1:0] s_axi_araddr,            // Read address
    input  wire logic              s_axi_arvalid,           // Read address valid
    output logic                   s_axi_arready,           // Read address ready
    output logic [31:0]            s_axi_rdata,             // Read data
    output logic [1:0]             s_axi_rresp,             // Read response
    output logic                   s_axi_rvalid,            // Read data valid
    input  wire logic              s_axi_rready,            // Read data ready
    output sts_pkg::sts_thr_t      x_operate_threshold_one, // X operate, set one
    output sts_pkg::sts_thr_t      x_return_threshold_one,  // X return, set one
    output sts_pkg::sts_thr_t      x_operate_threshold_two, // X operate, set two
    output sts_pkg::sts_thr_t      x_return_threshold_two,  // X return, set two
    output sts_pkg::sts_thr_t      y_operate_threshold_one, // Y operate, set one
    output sts_pkg::sts_thr_t      y_return_threshold_one,  // Y return, set one
    output sts_pkg::sts_thr_t      y_operate_threshold_two, // Y operate, set two
    output sts_pkg::sts_thr_t      y_return_threshold_two,  // Y return, set two
    output sts_pkg::sts_thr_t      z_operate_threshold_one, // Z operate, set one
    output sts_pkg::sts_thr_t      z_return_threshold_one,  // Z return, set one
    output sts_pkg::sts_thr_t      z_operate_threshold_two, // Z operate, set two
    output sts_pkg::sts_thr_t      z_return_threshold_two,  // Z return, set two
    output logic                   soft_reset_request       // Soft reset in progress
);
    localparam int NTHR = `STS_THR_COUNT;

    // All checks run on the bus clock and rest while reset is applied
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sts_pkg::sts_wr_state_t wr_state;
    sts_pkg::sts_thr_t      thr [NTHR];
    logic              aw_have;
    logic              w_have;
    logic [5:0]        aw_idx;
    logic [31:0]       wdata_q;
    logic [3:0]        wstrb_q;
    logic              wr_fire;
    logic              wr_hit_thr;
    logic              wr_hit_soft;
    logic [5:0]        wr_off;
    logic              soft_set;
    logic [5:0]        ar_idx;
    logic [5:0]        rd_off;
    logic [5:0]        ar_idx_q;
    logic [15:0]       wr_word;
    logic [15:0]       thr0_word;
    logic [7:0]        thr0_hi;
    logic              thr_all_default;

    // Word indices of the two channels; low address bits select nothing
    assign ar_idx = s_axi_araddr[7:2];
    assign wr_off = aw_idx - `STS_IDX_THR_BASE;
    assign rd_off = ar_idx - `STS_IDX_THR_BASE;

    // Twelve thresholds sit at consecutive indices from the base
    assign wr_hit_thr  = (aw_idx >= `STS_IDX_THR_BASE) && (wr_off < 6'(NTHR)); // R5
    assign wr_hit_soft = (aw_idx == `STS_IDX_SOFT_RESET); // R8

    // Address and data are each held once taken, in either order
    assign s_axi_awready = !aw_have && (wr_state == sts_pkg::STS_WR_COLLECT);
    assign s_axi_wready  = !w_have && (wr_state == sts_pkg::STS_WR_COLLECT);
    assign s_axi_bvalid  = (wr_state == sts_pkg::STS_WR_RESP);
    assign wr_fire       = aw_have && w_have && (wr_state == sts_pkg::STS_WR_COLLECT);

    // Write address holding register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have <= 1'b0;
            aw_idx  <= 6'h00;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_have <= 1'b1;
            aw_idx  <= s_axi_awaddr[7:2];
        end else if (s_axi_bvalid && s_axi_bready) begin
            aw_have <= 1'b0;
        end
    end

    // Write data holding register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_have  <= 1'b0;
            wdata_q <= 32'h00000000;
            wstrb_q <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_have  <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
        end else if (s_axi_bvalid && s_axi_bready) begin
            w_have <= 1'b0;
        end
    end

    // Write state and response; unmapped writes are dropped with SLVERR
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_state    <= sts_pkg::STS_WR_COLLECT;
            s_axi_bresp <= `STS_RESP_OKAY;
        end else begin
            case (wr_state)
                sts_pkg::STS_WR_COLLECT: begin
                    if (wr_fire) begin
                        wr_state    <= sts_pkg::STS_WR_RESP;
                        s_axi_bresp <= (wr_hit_thr || wr_hit_soft) ? `STS_RESP_OKAY
                                                                   : `STS_RESP_SLVERR; // R3
                    end
                end
                sts_pkg::STS_WR_RESP: begin
                    if (s_axi_bready) begin
                        wr_state <= sts_pkg::STS_WR_COLLECT;
                    end
                end
                default: begin
                    wr_state <= sts_pkg::STS_WR_COLLECT;
                end
            endcase
        end
    end

    // Only D0 is a storage bit; D7..D1 have no flip-flop behind them
    assign soft_set = wr_fire && wr_hit_soft && wstrb_q[0] && wdata_q[`STS_SOFT_RESET_BIT]; // R9

    sts_soft_reset u_soft_reset (
        .aclk    (aclk),
        .aresetn (aresetn),
        .set     (soft_set),
        .req     (soft_reset_request)
    );

    // One word per threshold; values are taken raw, as the measurement path codes them
    for (genvar i = 0; i < NTHR; i++) begin : g_thr
        sts_thresh_word #(
            .RESET_VAL (`STS_THR_RESET)
        ) u_word (
            .aclk    (aclk),
            .aresetn (aresetn),
            .clear   (soft_reset_request), // R6
            .wr_en   (wr_fire && wr_hit_thr && (wr_off == 6'(i))), // R5
            .wstrb   (wstrb_q[1:0]),
            .wdata   (wdata_q[15:0]), // R2
            .value   (thr[i])
        );
    end

    // Threshold outputs in register order: operate one, return one, operate two, return two
    assign x_operate_threshold_one = thr[0]; // R1
    assign x_return_threshold_one  = thr[1];
    assign x_operate_threshold_two = thr[2];
    assign x_return_threshold_two  = thr[3];
    assign y_operate_threshold_one = thr[4];
    assign y_return_threshold_one  = thr[5];
    assign y_operate_threshold_two = thr[6];
    assign y_return_threshold_two  = thr[7];
    assign z_operate_threshold_one = thr[8];
    assign z_return_threshold_one  = thr[9];
    assign z_operate_threshold_two = thr[10];
    assign z_return_threshold_two  = thr[11];

    // One read at a time, answered the cycle after the address is taken
    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h00000000;
            s_axi_rresp  <= `STS_RESP_OKAY;
            ar_idx_q     <= 6'h00;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            ar_idx_q     <= ar_idx;
            s_axi_rresp  <= `STS_RESP_OKAY;
            if ((ar_idx >= `STS_IDX_THR_BASE) && (rd_off < 6'(NTHR))) begin
                s_axi_rdata <= {16'h0000, thr[rd_off[3:0]]}; // R4
            end else if (ar_idx == `STS_IDX_SOFT_RESET) begin
                s_axi_rdata <= {31'h00000000, soft_reset_request}; // R9
            end else begin
                s_axi_rdata <= 32'h00000000;
                s_axi_rresp <= `STS_RESP_SLVERR;
            end
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // Helper views for the checks below
    assign wr_word   = wdata_q[15:0];
    assign thr0_word = thr[0];
    assign thr0_hi   = thr[0][15:8];

    always_comb begin
        thr_all_default = 1'b1;
        for (int k = 0; k < NTHR; k++) begin
            if (thr[k] != `STS_THR_RESET) begin
                thr_all_default = 1'b0;
            end
        end
    end

    // A full word write lands unchanged in the threshold
    property p_full_write;
        wr_fire && wr_hit_thr && (wr_off == 6'h00) && (wstrb_q[1:0] == 2'h3) && !soft_reset_request
        |=> x_operate_threshold_one == $past(wr_word);
    endproperty
    a_full_write: assert property (p_full_write) else $error("threshold word not stored"); // R2

    // A low-lane-only write leaves the high byte alone
    property p_low_lane;
        wr_fire && wr_hit_thr && (wr_off == 6'h00) && (wstrb_q[1:0] == 2'h1) && !soft_reset_request
        |=> $stable(thr0_hi) && (thr0_word[7:0] == $past(wdata_q[7:0]));
    endproperty
    a_low_lane: assert property (p_low_lane) else $error("byte lane mix-up"); // R4

    // A write to another threshold never touches the first one
    property p_axis_indep;
        wr_fire && wr_hit_thr && (wr_off != 6'h00) && !soft_reset_request |=> $stable(thr0_word);
    endproperty
    a_axis_indep: assert property (p_axis_indep) else $error("threshold written by foreign index"); // R5

    // Soft reset brings every threshold back to default
    property p_soft_clear;
        soft_reset_request |=> thr_all_default;
    endproperty
    a_soft_clear: assert property (p_soft_clear) else $error("threshold survived soft reset"); // R6

    // The request bit drops by itself one cycle later
    property p_self_clear;
        soft_reset_request |=> !soft_reset_request;
    endproperty
    a_self_clear: assert property (p_self_clear) else $error("soft reset bit stuck"); // R7

    // Writing one to D0 raises the request next cycle
    property p_soft_set;
        wr_fire && wr_hit_soft && wstrb_q[0] && wdata_q[0] |=> soft_reset_request ##1 thr_all_default;
    endproperty
    a_soft_set: assert property (p_soft_set) else $error("soft reset write ignored"); // R8

    // Soft reset register upper bits always read zero
    property p_upper_zero;
        s_axi_rvalid && (ar_idx_q == `STS_IDX_SOFT_RESET) |-> (s_axi_rdata[31:1] == 31'h00000000);
    endproperty
    a_upper_zero: assert property (p_upper_zero) else $error("soft reset upper bits nonzero"); // R9

    // Read of the first threshold returns its signed word in the low half
    property p_read_back;
        s_axi_arvalid && s_axi_arready && (ar_idx == `STS_IDX_THR_BASE)
        |=> s_axi_rvalid && (s_axi_rdata == {16'h0000, $past(thr0_word)});
    endproperty
    a_read_back: assert property (p_read_back) else $error("threshold read-back wrong"); // R1

    // Any value written to a threshold is accepted with OKAY
    property p_any_value;
        wr_fire && wr_hit_thr |=> s_axi_bvalid && (s_axi_bresp == `STS_RESP_OKAY);
    endproperty
    a_any_value: assert property (p_any_value) else $error("threshold write refused"); // R3

    // A high-lane-only write leaves the low byte alone
    property p_high_lane;
        wr_fire && wr_hit_thr && (wr_off == 6'h00) && (wstrb_q[1:0] == 2'h2) && !soft_reset_request
        |=> $stable(thr0_word[7:0]) && (thr0_hi == $past(wdata_q[15:8]));
    endproperty
    a_high_lane: assert property (p_high_lane) else $error("high byte lane mix-up"); // R4

    // Threshold reads leave the upper half of the bus word zero
    property p_read_upper;
        s_axi_rvalid && (ar_idx_q >= `STS_IDX_THR_BASE) && (ar_idx_q < `STS_IDX_SOFT_RESET)
        |-> (s_axi_rdata[31:16] == 16'h0000);
    endproperty
    a_read_upper: assert property (p_read_upper) else $error("threshold read upper half nonzero"); // R4

    // A soft reset write with D0 clear never raises the request
    property p_soft_quiet;
        wr_fire && wr_hit_soft && !(wstrb_q[0] && wdata_q[`STS_SOFT_RESET_BIT]) |=> !soft_reset_request;
    endproperty
    a_soft_quiet: assert property (p_soft_quiet) else $error("soft reset raised without request"); // R9

    // Unmapped writes store nothing and answer with an error
    property p_unmapped_wr;
        wr_fire && !wr_hit_thr && !wr_hit_soft
        |=> s_axi_bvalid && (s_axi_bresp == `STS_RESP_SLVERR) && $stable(thr0_word);
    endproperty
    a_unmapped_wr: assert property (p_unmapped_wr) else $error("unmapped write not refused"); // R5

    // The request only ever answers a host write of one
    property p_soft_cause;
        !soft_set |=> !soft_reset_request;
    endproperty
    a_soft_cause: assert property (p_soft_cause) else $error("soft reset request without cause"); // R8

    c_thr_write:  cover property (wr_fire && wr_hit_thr);
    c_soft_reset: cover property (soft_set ##1 soft_reset_request ##1 !soft_reset_request);
    c_lane_high:  cover property (wr_fire && wr_hit_thr && (wstrb_q[1:0] == 2'h2));
    c_bad_read:   cover property (s_axi_rvalid && (s_axi_rresp == `STS_RESP_SLVERR));
    c_neg_thr:    cover property (x_operate_threshold_one < 0);
endmodule
`default_nettype wire
